// ---- dv/mcuc_core_asserts.sv ----
`default_nettype none
// Watches the core at its pins only
module mcuc_core_asserts (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [9:0] pm_addr_o,
    input wire logic [7:0] port_o,
    input wire logic [7:0] working_register_o,
    input wire logic [3:0] status_o,
    input wire logic retire_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // A retire is one clock wide, then three quiet clocks
    sequence s_quiet3;
        !retire_o [*3];
    endsequence
    property p_pulse; retire_o |=> s_quiet3; endproperty
    a_pulse: assert property (p_pulse) else $error("retire spacing");
    property p_gap; retire_o |-> ##[4:8] retire_o; endproperty
    a_gap: assert property (p_gap) else $error("retire gap");
    // Address moves on the retire edge itself, then holds the whole cycle
    property p_fetch; retire_o |=> ##1 $stable(pm_addr_o) [*3]; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch address moved");
    property p_flags; $changed(status_o) |-> $past(retire_o); endproperty
    a_flags: assert property (p_flags) else $error("flags off retire");
    property p_wr; $changed(working_register_o) |-> $past(retire_o); endproperty
    a_wr: assert property (p_wr) else $error("working reg off retire");
    property p_port; $changed(port_o) |-> $past(retire_o); endproperty
    a_port: assert property (p_port) else $error("port off retire");
    // A lost cycle never runs longer than one instruction cycle
    property p_bub;
        retire_o ##1 s_quiet3 ##1 !retire_o |=> s_quiet3 ##1 retire_o;
    endproperty
    a_bub: assert property (p_bub) else $error("bubble length");
    // Reset is checked with the default disable switched off
    property p_rst;
        disable iff (1'b0) reset_i |=> port_o == 8'hFF && status_o == 4'h0 && !retire_o;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values");
endmodule // mcuc_core_asserts

bind mcuc_core mcuc_core_asserts u_chk (.mclk_i, .reset_i, .pm_addr_o, .port_o,
    .working_register_o, .status_o, .retire_o);
`default_nettype wire

// ---- dv/tb.sv ----
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct { logic [7:0] a; logic [13:0] op; logic [7:0] w; logic [3:0] s; } mcuc_row_t;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [13:0] pm_data_i = 14'h0000;
    logic [7:0] port_i = 8'h5A;
    logic [9:0] pm_addr_o;
    logic [7:0] port_o, working_register_o;
    logic [3:0] status_o;
    logic retire_o;
    logic [13:0] prog [1024];
    int n_fail = 0, tests_run = 0, cyc = 0;
    // Immediate load, one operation, then parked on a jump to itself
    mcuc_row_t rows [8] = '{'{8'hFF, 14'h2101, 8'h00, 4'h7}, '{8'h7F, 14'h2101, 8'h80, 4'hA},
        '{8'h00, 14'h2301, 8'hFF, 4'h0}, '{8'h05, 14'h2305, 8'h00, 4'h7},
        '{8'hF0, 14'h250F, 8'h00, 4'h4}, '{8'hF0, 14'h260F, 8'hFF, 4'h0},
        '{8'hAA, 14'h27AA, 8'h00, 4'h4}, '{8'h00, 14'h0013, 8'h5A, 4'h0}};
    mcuc_core uut (.mclk_i, .reset_i, .pm_addr_o, .pm_data_i, .port_i, .port_o,
        .working_register_o, .status_o, .retire_o);
    always #4 mclk_i = ~mclk_i;
    // Program memory answers well inside the four clocks allowed
    always @(posedge mclk_i) pm_data_i <= prog[pm_addr_o];
    // Hang guard, far above the 850 or so clocks needed
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic go();
        reset_i <= 1'b1;
        repeat (10) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (60) @(posedge mclk_i);
    endtask
    task automatic stop_test();
        if (n_fail == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        int k;
        for (int i = 0; i < 8; i++) begin
            prog = '{default: 14'h3002};
            prog[0] = {6'h20, rows[i].a};
            prog[1] = rows[i].op;
            go();
            chk("wr", rows[i].w, working_register_o);
            chk("st", {4'h0, rows[i].s}, {4'h0, status_o});
        end
        // Parked jump: two instruction cycles, eight clocks, each
        k = 0;
        repeat (80) begin
            @(posedge mclk_i);
            k += int'(retire_o === 1'b1);
        end
        chk("retires", 8'd10, 8'(k));
        // Call, load in the subroutine, return to the word after the call
        prog = '{default: 14'h3002};
        prog[0] = 14'h3804;
        prog[1] = 14'h2055;
        prog[4] = 14'h2011;
        prog[5] = 14'h2200;
        go();
        chk("ret", 8'h55, working_register_o);
        // Skip on clear carry, add one, clear bit 3 of the port latch
        prog = '{default: 14'h3004};
        prog[0] = 14'h1C0A;
        prog[1] = 14'h2022;
        prog[2] = 14'h2101;
        prog[3] = 14'h1592;
        go();
        chk("skip", 8'h01, working_register_o);
        chk("port", 8'hF7, port_o);
        // RAM store, increment, rotate, low byte jump, decrement, table read
        prog = '{default: 14'h3009};
        prog[0] = 14'h20F1;
        prog[1] = 14'h00C0;
        prog[2] = 14'h09C0;
        prog[3] = 14'h0E40;
        prog[4] = 14'h2007;
        prog[5] = 14'h0082;
        prog[6] = 14'h09C0;
        prog[7] = 14'h0A40;
        prog[8] = 14'h0F40;
        prog[9] = 14'h0040;
        prog[241] = 14'h1234;
        go();
        chk("table", 8'h34, working_register_o);
        chk("carry", 8'h01, {4'h0, status_o});
        stop_test();
    end
endmodule // tb
`default_nettype wire

// ---- rtl/mcuc_alu.sv ----
`default_nettype none

module mcuc_alu (
    // Operation port
    mcuc_alu_if.alu a
);
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] addend;
    logic add_cin;
    logic is_arith;
    logic is_sub;

    // ----------------------------------------------------------------
    // Adder front end
    // ----------------------------------------------------------------
    // Subtract is working minus operand, done as add of the inverse
    always_comb begin
        is_sub = (a.op == mcuc_pkg::MCUC_SUB) || (a.op == mcuc_pkg::MCUC_SUB_CARRY);
        is_arith = is_sub || (a.op == mcuc_pkg::MCUC_ADD) || (a.op == mcuc_pkg::MCUC_ADD_CARRY);
        addend = is_sub ? ~a.operand : a.operand;
        case (a.op)
            mcuc_pkg::MCUC_SUB: add_cin = 1'b1;
            mcuc_pkg::MCUC_ADD_CARRY, mcuc_pkg::MCUC_SUB_CARRY: add_cin = a.carry_in;
            default: add_cin = 1'b0;
        endcase
        sum = {1'b0, a.working} + {1'b0, addend} + {8'h00, add_cin};
        nib = {1'b0, a.working[3:0]} + {1'b0, addend[3:0]} + {4'h0, add_cin};
    end

    // ----------------------------------------------------------------
    // Result and flags
    // ----------------------------------------------------------------
    always_comb begin
        a.result = a.operand;
        a.carry = a.carry_in;
        a.flag_mask = 4'h0;
        case (a.op)
            mcuc_pkg::MCUC_TRANSFER_DATA: a.result = a.operand;
            mcuc_pkg::MCUC_PASS_WORKING: a.result = a.working;
            mcuc_pkg::MCUC_ADD, mcuc_pkg::MCUC_ADD_CARRY,
            mcuc_pkg::MCUC_SUB, mcuc_pkg::MCUC_SUB_CARRY: begin
                a.result = sum[7:0];
                a.carry = sum[8];
                a.flag_mask = 4'hF;
            end
            mcuc_pkg::MCUC_AND: begin
                a.result = a.working & a.operand;
                a.flag_mask[mcuc_pkg::ST_Z] = 1'b1;
            end
            mcuc_pkg::MCUC_OR: begin
                a.result = a.working | a.operand;
                a.flag_mask[mcuc_pkg::ST_Z] = 1'b1;
            end
            mcuc_pkg::MCUC_XOR: begin
                a.result = a.working ^ a.operand;
                a.flag_mask[mcuc_pkg::ST_Z] = 1'b1;
            end
            mcuc_pkg::MCUC_COMPLEMENT: begin
                a.result = ~a.operand;
                a.flag_mask[mcuc_pkg::ST_Z] = 1'b1;
            end
            mcuc_pkg::MCUC_PLUS_ONE: begin
                a.result = a.operand + 8'h01;
                a.flag_mask[mcuc_pkg::ST_Z] = 1'b1;
            end
            mcuc_pkg::MCUC_MINUS_ONE: begin
                a.result = a.operand - 8'h01;
                a.flag_mask[mcuc_pkg::ST_Z] = 1'b1;
            end
            // Plain rotates touch no flag at all
            mcuc_pkg::MCUC_ROTATE_RIGHT: a.result = {a.operand[0], a.operand[7:1]};
            mcuc_pkg::MCUC_ROTATE_LEFT: a.result = {a.operand[6:0], a.operand[7]};
            mcuc_pkg::MCUC_ROTATE_RIGHT_VIA_CARRY: begin
                a.result = {a.carry_in, a.operand[7:1]};
                a.carry = a.operand[0];
                a.flag_mask[mcuc_pkg::ST_C] = 1'b1;
            end
            mcuc_pkg::MCUC_ROTATE_LEFT_VIA_CARRY: begin
                a.result = {a.operand[6:0], a.carry_in};
                a.carry = a.operand[7];
                a.flag_mask[mcuc_pkg::ST_C] = 1'b1;
            end
            default: a.result = a.operand;
        endcase
        a.zero = (a.result == 8'h00);
        a.aux_carry = is_arith ? nib[4] : 1'b0;
        a.overflow = is_arith ? ((a.working[7] == addend[7]) && (sum[7] != a.working[7])) : 1'b0;
    end
endmodule // mcuc_alu

`default_nettype wire

// ---- rtl/mcuc_alu_if.sv ----
`default_nettype none

// Operands in, result and flags out
interface mcuc_alu_if;
    mcuc_pkg::mcuc_alu_op_t op;
    logic [7:0] operand;
    logic [7:0] working;
    logic carry_in;
    logic [7:0] result;
    logic carry;
    logic aux_carry;
    logic overflow;
    logic zero;
    logic [3:0] flag_mask;

    modport core (output op, operand, working, carry_in,
                  input result, carry, aux_carry, overflow, zero, flag_mask);
    modport alu (input op, operand, working, carry_in,
                 output result, carry, aux_carry, overflow, zero, flag_mask);
endinterface

`default_nettype wire

// ---- rtl/mcuc_core.sv ----
`default_nettype none

// Summary of operation
// - Ordinary instructions take one instruction cycle; jumps, calls, returns and table reads take two.
// - Each instruction cycle is exactly four system clock periods.
// - Writing the program counter low byte jumps there and costs one extra instruction cycle.
// - A conditional skip takes one cycle when not skipping and one more when it skips.
// - Moves go memory to working register, working register to memory, and immediate to working register.
// - Add sets carry above 255, subtract signals borrow below zero, both in the carry flag.
// - Increment and decrement change the value by exactly one, result to memory or working register.
// - AND, OR, XOR and complement exist and set the zero flag when the result is zero.
// - Rotates move one bit left or right; through-carry forms swap the outgoing bit with carry.
// - A call saves the address after itself and a return resumes exactly there.
// - A jump loads the target and saves no return address.
// - Conditional branches test a memory value or one bit and then execute or skip the next word.
// - Bit set and clear change one bit of a location, ports included, and keep the rest.
// - Add and subtract, with or without carry, update zero, carry, auxiliary carry and overflow.
// - Plain right rotate keeps all flags; right rotate through carry changes carry only.
// - AND, OR and XOR touch only the zero flag.
module mcuc_core #(
    parameter int RAM_WORDS = mcuc_pkg::RAM_DEPTH
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Program memory, word sampled in the fourth clock after the address
    output logic [mcuc_pkg::PC_W-1:0] pm_addr_o,
    input wire logic [mcuc_pkg::IR_W-1:0] pm_data_i,
    // General purpose port
    input wire logic [7:0] port_i,
    output logic [7:0] port_o,
    // Observation
    output logic [7:0] working_register_o,
    output logic [3:0] status_o,
    output logic retire_o
);
    localparam int RAM_AW = $clog2(RAM_WORDS);

    mcuc_pkg::mcuc_state_t s_q;
    mcuc_pkg::mcuc_state_t s_d;
    mcuc_alu_if alu_bus ();

    logic [mcuc_pkg::DADDR_W-1:0] ir_m;
    logic [1:0] grp;
    logic [3:0] opf;
    logic [1:0] bop;
    logic [2:0] bit_sel;
    logic [7:0] imm;
    logic [7:0] ram_rdata;
    logic [7:0] operand_rd;
    logic ram_sel;
    logic ram_we;
    logic mem_we;
    logic [mcuc_pkg::DADDR_W-1:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic redirect;
    logic skip;
    logic [mcuc_pkg::PC_W-1:0] target;
    logic exec;

    // ----------------------------------------------------------------
    // Field split of the word being executed
    // ----------------------------------------------------------------
    assign grp = s_q.ir[mcuc_pkg::F_GRP_HI:mcuc_pkg::F_GRP_LO];
    assign opf = s_q.ir[mcuc_pkg::F_OP_HI:mcuc_pkg::F_OP_LO];
    assign bop = s_q.ir[mcuc_pkg::F_BOP_HI:mcuc_pkg::F_BOP_LO];
    assign bit_sel = s_q.ir[mcuc_pkg::F_BIT_HI:mcuc_pkg::F_BIT_LO];
    assign imm = s_q.ir[7:0];
    assign ir_m = s_q.ir[mcuc_pkg::DADDR_W-1:0];
    assign ram_sel = (ir_m[6:5] == mcuc_pkg::RAM_PAGE);
    assign exec = s_q.ir_valid && (s_q.phase == mcuc_pkg::PH_LAST);

    // ----------------------------------------------------------------
    // Sub-blocks
    // ----------------------------------------------------------------
    mcuc_dmem #(
        .WIDTH(8),
        .DEPTH(RAM_WORDS)
    ) u_dmem (
        .mclk_i(mclk_i),
        .we_i(ram_we),
        .waddr_i(mem_waddr[RAM_AW-1:0]),
        .wdata_i(mem_wdata),
        .raddr_i(ir_m[RAM_AW-1:0]),
        .rdata_o(ram_rdata)
    );

    mcuc_alu u_alu (
        .a(alu_bus.alu)
    );

    // ----------------------------------------------------------------
    // Operand read mux, special registers before RAM
    // ----------------------------------------------------------------
    // Port output latch and pins sit at separate addresses so bit
    // changes work on the latch, not on a pin pulled by the load
    always_comb begin
        case (ir_m)
            mcuc_pkg::ADDR_PCL: operand_rd = s_q.pc[7:0];
            mcuc_pkg::ADDR_TBLH: operand_rd = {2'h0, s_q.tblh};
            mcuc_pkg::ADDR_STATUS: operand_rd = {4'h0, s_q.status};
            mcuc_pkg::ADDR_PORT_OUT: operand_rd = s_q.port_out;
            mcuc_pkg::ADDR_PORT_IN: operand_rd = s_q.port_in;
            default: operand_rd = ram_sel ? ram_rdata : 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // ALU operand selection
    // ----------------------------------------------------------------
    always_comb begin
        alu_bus.working = s_q.working_register;
        alu_bus.carry_in = s_q.status[mcuc_pkg::ST_C];
        alu_bus.operand = (grp == mcuc_pkg::GRP_IMM) ? imm : s_q.mval;
        alu_bus.op = mcuc_pkg::mcuc_alu_op_t'(opf);
        // Working register into memory reuses the transfer code
        if ((grp == mcuc_pkg::GRP_MEM) && (opf == 4'(mcuc_pkg::MCUC_TRANSFER_DATA))
                && s_q.ir[mcuc_pkg::F_DEST]) begin
            alu_bus.op = mcuc_pkg::MCUC_PASS_WORKING;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        mem_we = 1'b0;
        mem_waddr = ir_m;
        mem_wdata = alu_bus.result;
        redirect = 1'b0;
        skip = 1'b0;
        target = s_q.pc;

        // Pin synchroniser, accepted once the last two stages agree
        s_d.sync1 = port_i;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        for (int i = 0; i < 8; i++) begin
            if (s_q.sync2[i] == s_q.sync3[i]) begin
                s_d.port_in[i] = s_q.sync3[i];
            end
        end

        // Four clock phases per instruction cycle
        s_d.phase = s_q.phase + 2'h1;

        // Operand captured two edges after the RAM address settles
        if (s_q.phase == mcuc_pkg::PH_READ) begin
            s_d.mval = operand_rd;
        end

        if (exec) begin
            case (grp)
                mcuc_pkg::GRP_MEM: begin
                    if (opf == mcuc_pkg::MEM_TABLE_READ) begin
                        // Bus was lent to the table, so the prefetch is gone
                        mem_we = 1'b1;
                        mem_wdata = pm_data_i[7:0];
                        s_d.tblh = pm_data_i[13:8];
                        redirect = 1'b1;
                        target = s_q.pc;
                    end else begin
                        if (s_q.ir[mcuc_pkg::F_DEST]) begin
                            mem_we = 1'b1;
                        end else begin
                            s_d.working_register = alu_bus.result;
                        end
                        for (int f = 0; f < 4; f++) begin
                            if (alu_bus.flag_mask[f]) begin
                                s_d.status[f] = (f == mcuc_pkg::ST_C) ? alu_bus.carry :
                                                (f == mcuc_pkg::ST_AC) ? alu_bus.aux_carry :
                                                (f == mcuc_pkg::ST_Z) ? alu_bus.zero :
                                                alu_bus.overflow;
                            end
                        end
                    end
                end
                mcuc_pkg::GRP_BIT: begin
                    case (bop)
                        mcuc_pkg::BOP_SET: begin
                            mem_we = 1'b1;
                            mem_wdata = s_q.mval | (8'h01 << bit_sel);
                        end
                        mcuc_pkg::BOP_CLR: begin
                            mem_we = 1'b1;
                            mem_wdata = s_q.mval & ~(8'h01 << bit_sel);
                        end
                        mcuc_pkg::BOP_SKIP_SET: skip = s_q.mval[bit_sel];
                        mcuc_pkg::BOP_SKIP_CLR: skip = !s_q.mval[bit_sel];
                        default: skip = 1'b0;
                    endcase
                end
                mcuc_pkg::GRP_IMM: begin
                    case (opf)
                        mcuc_pkg::IMM_RET, mcuc_pkg::IMM_GO_BACK_FROM_INTERRUPT: begin
                            redirect = 1'b1;
                            target = s_q.ret_addr;
                        end
                        mcuc_pkg::IMM_SKIP_ZERO: begin
                            skip = (s_q.mval == 8'h00);
                        end
                        4'(mcuc_pkg::MCUC_TRANSFER_DATA), 4'(mcuc_pkg::MCUC_ADD),
                        4'(mcuc_pkg::MCUC_SUB), 4'(mcuc_pkg::MCUC_AND),
                        4'(mcuc_pkg::MCUC_OR), 4'(mcuc_pkg::MCUC_XOR): begin
                            s_d.working_register = alu_bus.result;
                            for (int f = 0; f < 4; f++) begin
                                if (alu_bus.flag_mask[f]) begin
                                    s_d.status[f] = (f == mcuc_pkg::ST_C) ? alu_bus.carry :
                                                    (f == mcuc_pkg::ST_AC) ? alu_bus.aux_carry :
                                                    (f == mcuc_pkg::ST_Z) ? alu_bus.zero :
                                                    alu_bus.overflow;
                                end
                            end
                        end
                        default: skip = 1'b0;
                    endcase
                end
                mcuc_pkg::GRP_BRA: begin
                    redirect = 1'b1;
                    target = s_q.ir[mcuc_pkg::PC_W-1:0];
                    if (s_q.ir[mcuc_pkg::F_CALL]) begin
                        // Prefetch address is already the word after the call
                        s_d.ret_addr = s_q.pc;
                    end
                end
                default: skip = 1'b0;
            endcase

            // Special register writes
            if (mem_we) begin
                case (mem_waddr)
                    mcuc_pkg::ADDR_PCL: begin
                        redirect = 1'b1;
                        target = {s_q.pc[mcuc_pkg::PC_W-1:8], mem_wdata};
                    end
                    mcuc_pkg::ADDR_STATUS: begin
                        if (!(|alu_bus.flag_mask) || (grp != mcuc_pkg::GRP_MEM)) begin
                            s_d.status = mem_wdata[3:0];
                        end
                    end
                    mcuc_pkg::ADDR_PORT_OUT: s_d.port_out = mem_wdata;
                    default: s_d.port_out = s_d.port_out;
                endcase
            end
        end

        // Fetch pipeline at the end of every instruction cycle
        if (s_q.phase == mcuc_pkg::PH_LAST) begin
            if (redirect) begin
                s_d.ir_valid = 1'b0;
                s_d.pc = target;
            end else if (skip) begin
                s_d.ir_valid = 1'b0;
                s_d.pc = s_q.pc + 10'h001;
            end else begin
                s_d.ir = pm_data_i;
                s_d.ir_valid = 1'b1;
                s_d.pc = s_q.pc + 10'h001;
            end
            // Table read borrows the program bus for its own cycle
            if (!redirect && !skip && (pm_data_i[13:12] == mcuc_pkg::GRP_MEM)
                    && (pm_data_i[11:8] == mcuc_pkg::MEM_TABLE_READ)) begin
                s_d.pm_addr = {s_q.pc[mcuc_pkg::PC_W-1:8], s_d.working_register};
            end else begin
                s_d.pm_addr = s_d.pc;
            end
        end
    end

    assign ram_we = mem_we && exec && ram_sel && (mem_waddr[6:5] == mcuc_pkg::RAM_PAGE);

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            s_q <= '0;
            s_q.pc <= mcuc_pkg::PC_RST;
            s_q.pm_addr <= mcuc_pkg::PC_RST;
            s_q.status <= mcuc_pkg::STATUS_RST;
            s_q.port_out <= mcuc_pkg::PORT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign pm_addr_o = s_q.pm_addr;
    assign port_o = s_q.port_out;
    assign working_register_o = s_q.working_register;
    assign status_o = s_q.status;
    assign retire_o = exec; // Pulse in the last clock of an executed word
endmodule // mcuc_core

`default_nettype wire

// ---- rtl/mcuc_dmem.sv ----
`default_nettype none

module mcuc_dmem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock
    input wire logic mclk_i,
    // Write port
    input wire logic we_i,
    input wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    // Read port, data one edge after the address
    input wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // No reset: general purpose RAM powers up undefined
    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule // mcuc_dmem

`default_nettype wire

// ---- rtl/mcuc_pkg.sv ----
`default_nettype none

package mcuc_pkg;

    // ----------------------------------------------------------------
    // Widths and timing
    // ----------------------------------------------------------------
    localparam int PC_W = 10;
    localparam int IR_W = 14;
    localparam int DADDR_W = 7;
    localparam int PHASE_W = 2;
    localparam int SYSCLK_PER_INSTR = 4;
    localparam logic [PHASE_W-1:0] PH_FETCH = 2'h0;
    localparam logic [PHASE_W-1:0] PH_READ = 2'h1;
    localparam logic [PHASE_W-1:0] PH_LAST = 2'(SYSCLK_PER_INSTR - 1);
    localparam int RAM_DEPTH = 32;

    // ----------------------------------------------------------------
    // Data memory map
    // ----------------------------------------------------------------
    localparam logic [DADDR_W-1:0] ADDR_PCL = 7'h02;
    localparam logic [DADDR_W-1:0] ADDR_TBLH = 7'h08;
    localparam logic [DADDR_W-1:0] ADDR_STATUS = 7'h0A;
    localparam logic [DADDR_W-1:0] ADDR_PORT_OUT = 7'h12;
    localparam logic [DADDR_W-1:0] ADDR_PORT_IN = 7'h13;
    localparam logic [1:0] RAM_PAGE = 2'h2;

    // ----------------------------------------------------------------
    // Status bit positions and reset values
    // ----------------------------------------------------------------
    localparam int ST_C = 0;
    localparam int ST_AC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam logic [3:0] STATUS_RST = 4'h0;
    localparam logic [PC_W-1:0] PC_RST = 10'h000;
    localparam logic [7:0] PORT_RST = 8'hFF;

    // ----------------------------------------------------------------
    // Instruction fields and groups
    // ----------------------------------------------------------------
    localparam int F_GRP_HI = 13;
    localparam int F_GRP_LO = 12;
    localparam int F_OP_HI = 11;
    localparam int F_OP_LO = 8;
    localparam int F_DEST = 7;
    localparam int F_BOP_HI = 11;
    localparam int F_BOP_LO = 10;
    localparam int F_BIT_HI = 9;
    localparam int F_BIT_LO = 7;
    localparam int F_CALL = 11;
    localparam logic [1:0] GRP_MEM = 2'h0;
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] GRP_IMM = 2'h2;
    localparam logic [1:0] GRP_BRA = 2'h3;
    localparam logic [3:0] MEM_TABLE_READ = 4'hF;
    localparam logic [3:0] IMM_RET = 4'h2;
    localparam logic [3:0] IMM_GO_BACK_FROM_INTERRUPT = 4'h4;
    localparam logic [3:0] IMM_SKIP_ZERO = 4'h8;
    localparam logic [1:0] BOP_SET = 2'h0;
    localparam logic [1:0] BOP_CLR = 2'h1;
    localparam logic [1:0] BOP_SKIP_SET = 2'h2;
    localparam logic [1:0] BOP_SKIP_CLR = 2'h3;

    // Operation codes shared by the instruction field and the ALU
    typedef enum logic [3:0] {
        MCUC_TRANSFER_DATA = 4'h0,
        MCUC_ADD = 4'h1,
        MCUC_ADD_CARRY = 4'h2,
        MCUC_SUB = 4'h3,
        MCUC_SUB_CARRY = 4'h4,
        MCUC_AND = 4'h5,
        MCUC_OR = 4'h6,
        MCUC_XOR = 4'h7,
        MCUC_COMPLEMENT = 4'h8,
        MCUC_PLUS_ONE = 4'h9,
        MCUC_MINUS_ONE = 4'hA,
        MCUC_ROTATE_RIGHT = 4'hB,
        MCUC_ROTATE_LEFT = 4'hC,
        MCUC_ROTATE_RIGHT_VIA_CARRY = 4'hD,
        MCUC_ROTATE_LEFT_VIA_CARRY = 4'hE,
        MCUC_PASS_WORKING = 4'hF
    } mcuc_alu_op_t;

    // Whole core state, registered as one word
    typedef struct packed {
        logic [PHASE_W-1:0] phase;
        logic [PC_W-1:0] pc;
        logic [PC_W-1:0] pm_addr;
        logic [PC_W-1:0] ret_addr;
        logic [IR_W-1:0] ir;
        logic ir_valid;
        logic [7:0] working_register;
        logic [3:0] status;
        logic [5:0] tblh;
        logic [7:0] mval;
        logic [7:0] port_out;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] sync3;
        logic [7:0] port_in;
    } mcuc_state_t;

endpackage

`default_nettype wire
